// [verilog/gcs_gpio_top.sv]
`timescale 1ns/10ps
`default_nettype none
module gcs_gpio_top #(
   parameter int unsigned ADDR_W = 9,
   parameter int unsigned NREG = 32,
   parameter logic [8*NREG-1:0] IMPL_MASK = '1,
   parameter logic [8*NREG-1:0] LOS_MASK = '0
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [gcs_pkg::NPIN-1:0] pinIn,
   output logic [gcs_pkg::NPIN-1:0] pinOut,
   output logic [gcs_pkg::NPIN-1:0] pinOe,
   input wire logic [8*NREG-1:0] statusIn
);

   localparam int unsigned NPIN = gcs_pkg::NPIN;
   localparam int unsigned REG_W = gcs_pkg::REG_W;
   localparam int unsigned IDX_W = gcs_pkg::IDX_W;
   localparam int unsigned CODE_W = gcs_pkg::CODE_W;

   // ==========================================================
   // Register file state
   logic [REG_W-1:0] cfg_reg [2];
   logic [REG_W-1:0] cfg_next [2];
   logic [REG_W-1:0] sel_reg [NPIN];
   logic [REG_W-1:0] sel_next [NPIN];
   logic [NPIN-1:0] level;
   logic [NPIN-1:0] followBit;
   logic [CODE_W-1:0] code [NPIN];

   // ==========================================================
   // Write channel state
   gcs_pkg::gcs_wr_state_t wrState_reg;
   gcs_pkg::gcs_wr_state_t wrState_next;
   logic awHeld_reg;
   logic awHeld_next;
   logic wHeld_reg;
   logic wHeld_next;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [ADDR_W-1:0] awAddr_next;
   logic [REG_W-1:0] wData_reg;
   logic [REG_W-1:0] wData_next;
   logic wLane_reg;
   logic wLane_next;
   logic awready_reg;
   logic awready_next;
   logic wready_reg;
   logic wready_next;
   logic bvalid_reg;
   logic bvalid_next;
   logic [1:0] bresp_reg;
   logic [1:0] bresp_next;

   // Values in force at the commit edge, held or arriving.
   logic awTake;
   logic wTake;
   logic doWrite;
   logic [IDX_W-1:0] wrIdx;
   logic [REG_W-1:0] wrData;
   logic wrLane;

   // ==========================================================
   // Read channel state
   gcs_pkg::gcs_rd_state_t rdState_reg;
   gcs_pkg::gcs_rd_state_t rdState_next;
   logic arready_reg;
   logic arready_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0] rresp_reg;
   logic [1:0] rresp_next;
   logic [IDX_W-1:0] rdIdx;

   // ==========================================================
   // Per-pin cells and status selection
   // Pins 0/1 live in the first config register, 2/3 in the second,
   // each pin taking one four-bit field, low pin in the low nibble.
   for (genvar n = 0; n < NPIN; n++) begin : gPin
      assign code[n] = cfg_reg[n/2][(n%2)*CODE_W +: CODE_W];

      gcs_status_pick #(
         .NREG(NREG),
         .IMPL_MASK(IMPL_MASK),
         .LOS_MASK(LOS_MASK)
      ) uPick (
         .statusIn(statusIn),
         .sel(sel_reg[n]),
         .followBit(followBit[n])
      );

      gcs_pin_cell uCell (
         .ref_clk(ref_clk),
         .arst_n(arst_n),
         .clkEn(clkEn),
         .pinIn(pinIn[n]),
         .code(code[n]),
         .followBit(followBit[n]),
         .pinOut(pinOut[n]),
         .pinOe(pinOe[n]),
         .level(level[n])
      );
   end

   // ==========================================================
   // Write address and data capture
   // Address and data may come in either order; whichever arrives first
   // is parked until the other one is taken, then the register is
   // updated at that same edge and the response is raised at that edge too.
   always_comb begin
      awTake = awvalid && awready_reg;
      wTake = wvalid && wready_reg;
      wrState_next = wrState_reg;
      awHeld_next = awHeld_reg || awTake;
      wHeld_next = wHeld_reg || wTake;
      awAddr_next = awTake ? awaddr : awAddr_reg;
      wData_next = wTake ? wdata[REG_W-1:0] : wData_reg;
      wLane_next = wTake ? wstrb[0] : wLane_reg;
      awready_next = awready_reg;
      wready_next = wready_reg;
      bvalid_next = bvalid_reg;
      doWrite = 1'b0;
      case (wrState_reg)
         gcs_pkg::WR_ACCEPT: begin
            doWrite = awHeld_next && wHeld_next;
            awready_next = !awHeld_next;
            wready_next = !wHeld_next;
            if (doWrite) begin
               wrState_next = gcs_pkg::WR_RESP;
               awready_next = 1'b0;
               wready_next = 1'b0;
               bvalid_next = 1'b1;
            end
         end
         gcs_pkg::WR_RESP: begin
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            if (bready) begin
               wrState_next = gcs_pkg::WR_ACCEPT;
               bvalid_next = 1'b0;
               awready_next = 1'b1;
               wready_next = 1'b1;
            end
         end
         default: begin
            wrState_next = gcs_pkg::WR_ACCEPT;
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            awready_next = 1'b0;
            wready_next = 1'b0;
            bvalid_next = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Register update
   // Only byte lane 0 carries a register; a write with that lane off
   // changes nothing but still answers OKAY at a config or select index.
   always_comb begin
      wrIdx = awAddr_next[2 +: IDX_W];
      wrData = wData_next;
      wrLane = wLane_next;
      cfg_next = cfg_reg;
      sel_next = sel_reg;
      bresp_next = bresp_reg;
      if (doWrite) begin
         bresp_next = gcs_pkg::RESP_OKAY;
      end
      case (wrIdx)
         gcs_pkg::IDX_PIN01_CFG: begin
            if (doWrite && wrLane) begin
               cfg_next[0] = wrData;
            end
         end
         gcs_pkg::IDX_PIN23_CFG: begin
            if (doWrite && wrLane) begin
               cfg_next[1] = wrData;
            end
         end
         gcs_pkg::IDX_SEL0, gcs_pkg::IDX_SEL1, gcs_pkg::IDX_SEL2,
         gcs_pkg::IDX_SEL3: begin
            if (doWrite && wrLane) begin
               sel_next[2'(wrIdx - gcs_pkg::IDX_SEL0)] = wrData;
            end
         end
         gcs_pkg::IDX_PIN_LEVEL: begin
            if (doWrite) begin
               bresp_next = gcs_pkg::RESP_SLVERR;
            end
         end
         default: begin
            if (doWrite) begin
               bresp_next = gcs_pkg::RESP_DECERR;
            end
         end
      endcase
   end

   // ==========================================================
   // Read channel
   // One read at a time; data is captured at the address edge so the
   // value stands unchanged for as long as the master stalls rready.
   always_comb begin
      rdIdx = araddr[2 +: IDX_W];
      rdState_next = rdState_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      case (rdState_reg)
         gcs_pkg::RD_ACCEPT: begin
            arready_next = 1'b1;
            if (arvalid && arready_reg) begin
               rdState_next = gcs_pkg::RD_RESP;
               arready_next = 1'b0;
               rvalid_next = 1'b1;
               rresp_next = gcs_pkg::RESP_OKAY;
               rdata_next = '0;
               case (rdIdx)
                  gcs_pkg::IDX_PIN01_CFG: rdata_next[REG_W-1:0] = cfg_reg[0];
                  gcs_pkg::IDX_PIN23_CFG: rdata_next[REG_W-1:0] = cfg_reg[1];
                  gcs_pkg::IDX_SEL0: rdata_next[REG_W-1:0] = sel_reg[0];
                  gcs_pkg::IDX_SEL1: rdata_next[REG_W-1:0] = sel_reg[1];
                  gcs_pkg::IDX_SEL2: rdata_next[REG_W-1:0] = sel_reg[2];
                  gcs_pkg::IDX_SEL3: rdata_next[REG_W-1:0] = sel_reg[3];
                  gcs_pkg::IDX_PIN_LEVEL: rdata_next[NPIN-1:0] = level;
                  default: rresp_next = gcs_pkg::RESP_DECERR;
               endcase
            end
         end
         gcs_pkg::RD_RESP: begin
            if (rready) begin
               rdState_next = gcs_pkg::RD_ACCEPT;
               rvalid_next = 1'b0;
               arready_next = 1'b1;
            end
         end
         default: begin
            rdState_next = gcs_pkg::RD_ACCEPT;
            arready_next = 1'b0;
            rvalid_next = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // State registers
   // Ready outputs come up one edge after reset release, since a flop
   // under asynchronous reset may only take a constant.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 2; i++) begin
            cfg_reg[i] <= gcs_pkg::REG_RESET;
         end
         for (int i = 0; i < NPIN; i++) begin
            sel_reg[i] <= gcs_pkg::REG_RESET;
         end
         wrState_reg <= gcs_pkg::WR_ACCEPT;
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= '0;
         wData_reg <= '0;
         wLane_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= gcs_pkg::RESP_OKAY;
         rdState_reg <= gcs_pkg::RD_ACCEPT;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= gcs_pkg::RESP_OKAY;
      end else if (clkEn) begin
         cfg_reg <= cfg_next;
         sel_reg <= sel_next;
         wrState_reg <= wrState_next;
         awHeld_reg <= awHeld_next;
         wHeld_reg <= wHeld_next;
         awAddr_reg <= awAddr_next;
         wData_reg <= wData_next;
         wLane_reg <= wLane_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rdState_reg <= rdState_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // ==========================================================
   // Outputs straight from flops
   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   // ==========================================================
   // Elaboration checks
   // Protection bits carry no meaning here; every access is served.
   if (ADDR_W < gcs_pkg::MIN_ADDR_W || ADDR_W > 32) begin : gAddrCheck
      $error("ADDR_W must be 9 to 32 to reach the pin level register.");
   end

endmodule
`default_nettype wire

// [include/gcs_pkg.sv]
// Overview of operation
// - Codes 0000/0001: plain and inverted input.
// - Codes 0010/0011: driven constant low/high.
// - Codes 0100/0101: push-pull status, true/inverted.
// - Codes 0110/0111: open-drain status, either polarity.
// - Every pin level readable in status register.
// - Status-select register picks the followed bit.
// - Two config registers, four bits per pin.
// - Select fields act only for codes 01xx.
// - Followed address is 0x40 plus index.
// - Bit index 000..111 picks bit 0..7.
// - Unimplemented followed bit is taken as 0.
// - Input clock loss bits never followed.
// - Pin level status bits never followed.
// - Pins 0..3 have identical select registers.
package gcs_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned NPIN = 4;
   localparam int unsigned REG_W = 8;
   localparam int unsigned CODE_W = 4;
   localparam int unsigned IDX_W = 7;
   localparam int unsigned REG_IDX_W = 5;
   localparam int unsigned BIT_IDX_W = 3;
   localparam int unsigned REG_IDX_LSB = 3;
   localparam int unsigned MIN_ADDR_W = 9;

   // ==========================================================
   // Register indices; byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_PIN01_CFG = 7'h0e;
   localparam logic [IDX_W-1:0] IDX_PIN23_CFG = 7'h0f;
   localparam logic [IDX_W-1:0] IDX_SEL0 = 7'h12;
   localparam logic [IDX_W-1:0] IDX_SEL1 = 7'h13;
   localparam logic [IDX_W-1:0] IDX_SEL2 = 7'h14;
   localparam logic [IDX_W-1:0] IDX_SEL3 = 7'h15;
   localparam logic [IDX_W-1:0] IDX_PIN_LEVEL = 7'h41;

   // Followed status space starts at this register address.
   localparam logic [REG_W-1:0] STATUS_BASE = 8'h40;
   // Pin level register seen as an index within the status space.
   localparam logic [REG_IDX_W-1:0] FOLLOW_IDX_PIN_LEVEL = 5'h01;
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;

   // ==========================================================
   // Pin function codes
   localparam logic [CODE_W-1:0] FN_IN = 4'h0;
   localparam logic [CODE_W-1:0] FN_IN_INV = 4'h1;
   localparam logic [CODE_W-1:0] FN_OUT_LO = 4'h2;
   localparam logic [CODE_W-1:0] FN_OUT_HI = 4'h3;
   localparam logic [CODE_W-1:0] FN_ST = 4'h4;
   localparam logic [CODE_W-1:0] FN_ST_INV = 4'h5;
   localparam logic [CODE_W-1:0] FN_OD_LOW0 = 4'h6;
   localparam logic [CODE_W-1:0] FN_OD_LOW1 = 4'h7;

   // ==========================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      WR_ACCEPT = 2'b01,
      WR_RESP = 2'b10
   } gcs_wr_state_t;

   typedef enum logic [1:0] {
      RD_ACCEPT = 2'b01,
      RD_RESP = 2'b10
   } gcs_rd_state_t;

endpackage

// [verilog/gcs_pin_cell.sv]
`timescale 1ns/10ps
`default_nettype none
module gcs_pin_cell (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic pinIn,
   input wire logic [gcs_pkg::CODE_W-1:0] code,
   input wire logic followBit,
   output logic pinOut,
   output logic pinOe,
   output logic level
);

   // ==========================================================
   // Synchroniser and reported level
   logic syncA_reg;
   logic syncB_reg;
   logic level_reg;
   logic pinOut_reg;
   logic pinOe_reg;
   logic level_next;
   logic pinOut_next;
   logic pinOe_next;

   // Second stage alone reads the first; inversion only on the clean copy.
   always_comb begin
      level_next = syncB_reg ^ (code == gcs_pkg::FN_IN_INV);
   end

   // ==========================================================
   // Pin drive decode
   // The follow bit is looked at only in the 01xx codes, so a stale
   // select value cannot disturb a pin that is not a status output.
   always_comb begin
      pinOut_next = 1'b0;
      pinOe_next = 1'b0;
      case (code)
         gcs_pkg::FN_IN, gcs_pkg::FN_IN_INV: begin
            pinOe_next = 1'b0;
         end
         gcs_pkg::FN_OUT_LO: begin
            pinOe_next = 1'b1;
         end
         gcs_pkg::FN_OUT_HI: begin
            pinOe_next = 1'b1;
            pinOut_next = 1'b1;
         end
         gcs_pkg::FN_ST: begin
            pinOe_next = 1'b1;
            pinOut_next = followBit;
         end
         gcs_pkg::FN_ST_INV: begin
            pinOe_next = 1'b1;
            pinOut_next = ~followBit;
         end
         gcs_pkg::FN_OD_LOW0: begin
            pinOe_next = ~followBit;
         end
         gcs_pkg::FN_OD_LOW1: begin
            pinOe_next = followBit;
         end
         default: begin
            pinOe_next = 1'b0;
         end
      endcase
   end

   // All state holds while the clock enable is low.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA_reg <= 1'b0;
         syncB_reg <= 1'b0;
         level_reg <= 1'b0;
         pinOut_reg <= 1'b0;
         pinOe_reg <= 1'b0;
      end else if (clkEn) begin
         syncA_reg <= pinIn;
         syncB_reg <= syncA_reg;
         level_reg <= level_next;
         pinOut_reg <= pinOut_next;
         pinOe_reg <= pinOe_next;
      end
   end

   assign pinOut = pinOut_reg;
   assign pinOe = pinOe_reg;
   assign level = level_reg;

endmodule
`default_nettype wire

// [verilog/gcs_status_pick.sv]
`timescale 1ns/10ps
`default_nettype none
module gcs_status_pick #(
   parameter int unsigned NREG = 32,
   parameter logic [8*NREG-1:0] IMPL_MASK = '1,
   parameter logic [8*NREG-1:0] LOS_MASK = '0
) (
   input wire logic [8*NREG-1:0] statusIn,
   input wire logic [gcs_pkg::REG_W-1:0] sel,
   output logic followBit
);

   // ==========================================================
   // Bit selection with refusal of forbidden and absent bits
   logic [gcs_pkg::REG_IDX_W-1:0] regIdx;
   logic [gcs_pkg::BIT_IDX_W-1:0] bitIdx;
   logic [gcs_pkg::REG_W-1:0] flat;
   logic refuse;

   // Register index sits above the bit index, giving one flat bit number
   // counted from the first status register.
   always_comb begin
      regIdx = sel[gcs_pkg::REG_IDX_LSB +: gcs_pkg::REG_IDX_W];
      bitIdx = sel[gcs_pkg::BIT_IDX_W-1:0];
      flat = {regIdx, bitIdx};
      refuse = 1'b1;
      followBit = 1'b0;
      if (32'(flat) < 8 * NREG) begin
         refuse = (regIdx == gcs_pkg::FOLLOW_IDX_PIN_LEVEL)
            || !IMPL_MASK[flat]
            || LOS_MASK[flat];
         followBit = refuse ? 1'b0 : statusIn[flat];
      end
   end

   if (NREG < 1 || NREG > 32) begin : gNregCheck
      $error("NREG must lie between 1 and 32.");
   end

endmodule
`default_nettype wire

// [test/gcs_gpio_props.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Checks on the top-level ports only.
module gcs_gpio_props #(
   parameter int unsigned ADDR_W = 9,
   parameter int unsigned NREG = 32,
   parameter logic [8*NREG-1:0] IMPL_MASK = '1,
   parameter logic [8*NREG-1:0] LOS_MASK = '0
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [3:0] pinOut,
   input wire logic [3:0] pinOe,
   input wire logic [8*NREG-1:0] statusIn
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Accepted transfers and quiet cycles with no write address taken and no status change.
   sequence wr_s; awvalid && awready && wvalid && wready && clkEn; endsequence
   sequence rd_s; arvalid && arready && clkEn; endsequence
   sequence quiet_s; clkEn && !(awvalid && awready) && $stable(statusIn); endsequence
   a_write_answer: assert property (wr_s |=> bvalid && !awready && !wready)
      else $error("write response missing");
   a_resp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_read_answer: assert property (rd_s |=> rvalid && !arready)
      else $error("read response missing");
   a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_level_ro: assert property (wr_s ##0 awaddr == 9'h104 |=> bresp == 2'h2)
      else $error("pin level write accepted");
   a_level_width: assert property (rd_s ##0 araddr == 9'h104 |=> rdata[31:4] == '0)
      else $error("pin level upper bits set");
   a_reset_pins: assert property (disable iff (1'b0) !arst_n |-> pinOe == '0)
      else $error("pin driven in reset");
   a_pins_quiet: assert property (quiet_s [*2] |=> $stable(pinOe) && $stable(pinOut))
      else $error("pin moved without cause");
endmodule
bind gcs_gpio_top gcs_gpio_props #(.ADDR_W(ADDR_W), .NREG(NREG), .IMPL_MASK(IMPL_MASK),
   .LOS_MASK(LOS_MASK)) gcs_gpio_props_inst (.*);
`default_nettype wire

// [test/gcs_pin_board.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Board wiring: device drive, outside driver, pull-up.
module gcs_pin_board (
   input wire logic [3:0] pinOut,
   input wire logic [3:0] pinOe,
   input wire logic [3:0] extEn,
   input wire logic [3:0] extLevel,
   output logic [3:0] pinIn
);
   // A released pin with no outside driver floats up to the pull-up level.
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         if (pinOe[p]) pinIn[p] = pinOut[p];
         else if (extEn[p]) pinIn[p] = extLevel[p];
         else pinIn[p] = 1'b1;
      end
   end
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ==========================================
   // Reg 2 holds loss bits; reg 31 is unimplemented.
   localparam logic [255:0] LOSM = 256'h00ff_0000;
   localparam logic [255:0] IMPLM = ~(256'hff << 248);
   logic ref_clk = 0, arst_n = 1, clkEn = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [8:0] awaddr = '0, araddr = '0;
   logic [2:0] awprot = '0, arprot = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0, pinIn, pinOut, pinOe, extEn = '0, extLevel = '0, exl;
   logic [1:0] bresp, rresp, pe;
   logic [255:0] statusIn = '0, st;
   logic [3:0] code [4];
   logic [7:0] sel [4];
   logic [7:0] corner [4] = '{8'h08, 8'h10, 8'hff, 8'h00};
   logic [8:0] regAddr [6] = '{9'h038, 9'h03c, 9'h048, 9'h04c, 9'h050, 9'h054};
   int fails = 0, total_checks = 0;
   gcs_gpio_top #(.IMPL_MASK(IMPLM), .LOS_MASK(LOSM)) gcs_gpio_top_inst (.*);
   gcs_pin_board gcs_pin_board_inst (.*);
   // Free-running 125 MHz clock.
   always #4 ref_clk = ~ref_clk;
   // ==========================================
   // Reporting.
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   task automatic hang;
      fails++;
      end_sim;
   endtask
   // ==========================================
   // Bus master; ready is registered, so its value at the falling edge is what the next
   // rising edge samples.
   task automatic axi_wr(input logic [8:0] a, input logic [7:0] d, input logic [3:0] s,
      input logic [1:0] er);
      int n;
      logic da, dw, ta, tw;
      n = 0;
      da = 0;
      dw = 0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= 32'(d);
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'($urandom);
      do begin
         @(negedge ref_clk);
         n++;
         if (n > 50) hang;
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge ref_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         da = da | ta;
         dw = dw | tw;
      end while (!(da && dw));
      do begin
         @(negedge ref_clk);
         n++;
         if (n > 100) hang;
         ta = bvalid && bready;
         if (ta) chk("bresp", 32'(er), 32'(bresp));
         @(posedge ref_clk);
         if (!ta) bready <= 1'b1;
      end while (!ta);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [8:0] a, input logic [31:0] ed, input logic [1:0] er,
      input string nm);
      int n;
      logic t;
      n = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'($urandom);
      do begin
         @(negedge ref_clk);
         n++;
         if (n > 50) hang;
         t = arvalid && arready;
         @(posedge ref_clk);
         if (t) arvalid <= 1'b0;
      end while (!t);
      do begin
         @(negedge ref_clk);
         n++;
         if (n > 100) hang;
         t = rvalid && rready;
         if (t) chk(nm, ed, rdata);
         if (t) chk("rresp", 32'(er), 32'(rresp));
         @(posedge ref_clk);
         if (!t) rready <= 1'b1;
      end while (!t);
      rready <= 1'b0;
   endtask
   // ==========================================
   // Expected followed bit, pin drive {oe, oe and out} and reported level.
   function automatic logic fbit(input logic [7:0] s);
      if (s[7:3] == 5'h01 || LOSM[s] || !IMPLM[s]) return 1'b0;
      return st[s];
   endfunction
   function automatic logic [1:0] pexp(input logic [3:0] c, input logic f);
      case (c)
         4'h2: return 2'b10;
         4'h3: return 2'b11;
         4'h4: return {1'b1, f};
         4'h5: return {1'b1, ~f};
         4'h6: return {~f, 1'b0};
         4'h7: return {f, 1'b0};
         default: return 2'b00;
      endcase
   endfunction
   // ==========================================
   // Main sequence.
   initial begin
      // Reset is entered by an edge at time zero so the flops clear before the first clock.
      arst_n <= 1'b0;
      void'($urandom(32'hd59a_aa05));
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      chk("pinOe", 32'h0, 32'(pinOe));
      foreach (regAddr[k]) axi_rd(regAddr[k], 32'h0, 2'h0, "reset value");
      axi_rd(9'h1fc, 32'h0, 2'h3, "unmapped");
      axi_wr(9'h1fc, 8'h55, 4'h1, 2'h3);
      axi_wr(9'h104, 8'h0f, 4'h1, 2'h2);
      for (int i = 0; i < 40; i++) begin
         extEn <= '0;
         for (int k = 0; k < 8; k++) st[32*k+:32] = $urandom;
         statusIn <= st;
         for (int p = 0; p < 4; p++) begin
            code[p] = (i < 4) ? 4'(i * 4 + p) : 4'($urandom);
            sel[p] = (i < 4) ? corner[p] : 8'($urandom);
         end
         axi_wr(9'h038, {code[1], code[0]}, 4'h1, 2'h0);
         axi_wr(9'h03c, {code[3], code[2]}, 4'h1, 2'h0);
         for (int p = 0; p < 4; p++) axi_wr(9'(72 + 4 * p), sel[p], 4'h1, 2'h0);
         @(negedge ref_clk);
         for (int p = 0; p < 4; p++) begin
            pe = pexp(code[p], fbit(sel[p]));
            chk("pin drive", 32'(pe), 32'({pinOe[p], pinOe[p] & pinOut[p]}));
            extEn[p] <= 1'($urandom) & !pe[1];
            extLevel[p] <= st[p];
            exl[p] = (pe[1] ? pe[0] : 1'b1) ^ (code[p] == 4'h1);
         end
         @(posedge ref_clk);
         for (int p = 0; p < 4; p++) begin
            if (extEn[p]) exl[p] = extLevel[p] ^ (code[p] == 4'h1);
         end
         repeat (5) @(posedge ref_clk);
         axi_rd(9'h104, 32'(exl), 2'h0, "pin level");
         axi_rd(9'h038, 32'({code[1], code[0]}), 2'h0, "pin01 config");
      end
      axi_wr(9'h038, 8'haa, 4'h0, 2'h0);
      axi_rd(9'h038, 32'({code[1], code[0]}), 2'h0, "masked write");
      // A low enable must hold the pins although the followed bits change.
      clkEn <= 1'b0;
      statusIn <= ~st;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      for (int p = 0; p < 4; p++) begin
         pe = pexp(code[p], fbit(sel[p]));
         chk("frozen drive", 32'(pe), 32'({pinOe[p], pinOe[p] & pinOut[p]}));
      end
      st = ~st;
      clkEn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      for (int p = 0; p < 4; p++) begin
         pe = pexp(code[p], fbit(sel[p]));
         chk("thawed drive", 32'(pe), 32'({pinOe[p], pinOe[p] & pinOut[p]}));
      end
      end_sim;
   end
endmodule
`default_nettype wire
